// >>> inc/lcis_pkg.sv
// Package with register map, field layout and source encodings for the input select stage
package lcis_pkg;

    // APB byte addresses of the registers
    localparam logic [7:0] GATE_SELECT_LOW_ADDR  = 8'h00;
    localparam logic [7:0] GATE_SELECT_HIGH_ADDR = 8'h04;
    localparam logic [7:0] SOURCE_SELECT_ADDR    = 8'h08;
    localparam logic [7:0] GATE_INVERT_ADDR      = 8'h0c;
    localparam logic [7:0] STATUS_ADDR           = 8'h10;

    // Reset values
    localparam logic [15:0] GATE_SELECT_LOW_RST  = 16'h0000;
    localparam logic [15:0] GATE_SELECT_HIGH_RST = 16'h0000;
    localparam logic [15:0] SOURCE_SELECT_RST    = 16'h0000;
    localparam logic [3:0]  GATE_INVERT_RST      = 4'h0;

    // Source select fields: 3 bits each, at a stride of 4 bits
    localparam int SEL_FIELD_STRIDE = 4;
    localparam int SEL_FIELD_WIDTH  = 3;
    // Gate enable fields: 8 bits per gate, two gates per register
    localparam int GATE_FIELD_WIDTH = 8;
    localparam int GATE_HIGH_LSB    = 8;

    localparam int NUM_SOURCES = 4;
    localparam int NUM_GATES   = 4;

    // Selector encodings, common to all four selectors
    typedef enum logic [2:0] {
        SEL_CODE_0,
        SEL_CODE_1,
        SEL_CODE_2,
        SEL_CODE_3,
        SEL_CODE_4,
        SEL_CODE_5,
        SEL_CODE_6,
        SEL_CODE_7
    } sel_code_t;

endpackage : lcis_pkg

// >>> design/input_gate.sv
// One input gate: OR of enabled true and negated source copies, then optional inversion
`timescale 1ns/1ps
module input_gate (
    // Source copies, index 0 is source one
    input  wire logic [3:0] src_true,
    input  wire logic [3:0] src_neg,
    // Enable byte, descending true/negated pairs for sources 4..1
    input  wire logic [7:0] enables,
    input  wire logic       invert,
    // Gate result
    output logic            gate_out
);
    logic [3:0] true_en;
    logic [3:0] neg_en;
    logic       or_term;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            true_en[i] = enables[2*i+1];
            neg_en[i]  = enables[2*i];
        end
        // Nothing enabled leaves the OR at zero
        or_term  = |((src_true & true_en) | (src_neg & neg_en));
        gate_out = or_term ^ invert;
    end
endmodule : input_gate

// >>> design/logic_cell_input_select.sv
// Input select stage of the fourth logic cell with its APB register file
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps

// What this block does
// - Selector one picks ext A, PWM7 high, timer1 match, RC clock, ref clock, fast PWM clock, timer2 match, PWM1 low.
// - Selector two picks ext B, cell three out, comparator 1, PWM7 low, end of conversion, PWM1 high, capture 1, capture 2.
// - Selector three picks ext A, own output, comparator 2, PWM8 high, UART2 receive, DMA1 interrupt, compare 1, PWM2 low.
// - Gate 1 enables sit in bits 7..0 of the low select register, true then negated, sources 4 down to 1.
// - Gate 2 enables sit in bits 15..8 of the low select register in the same order.
// - Gate 3 enables sit in bits 7..0 of the high select register in the same order.
// - Gate 4 enables sit in bits 15..8 of the high select register in the same order.
// - An enable bit at 1 includes its source copy in the gate, at 0 excludes it.
// - Each selector delivers its chosen signal and its complement to the gates.
// - Each gate is the OR of all copies enabled for it.
// - A per-gate invert bit at 1 inverts that gate output, at 0 passes it.
module logic_cell_input_select (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Source pins and on-chip signals
    input  wire logic        ext_input_a,
    input  wire logic        ext_input_b,
    input  wire logic        pwm_gen7_high,
    input  wire logic        pwm_gen7_low,
    input  wire logic        pwm_gen8_high,
    input  wire logic        pwm_gen8_low,
    input  wire logic        pwm_gen1_high,
    input  wire logic        pwm_gen1_low,
    input  wire logic        pwm_gen2_high,
    input  wire logic        pwm_gen2_low,
    input  wire logic        timer1_match,
    input  wire logic        timer2_match,
    input  wire logic        internal_rc_clock,
    input  wire logic        reference_clock_out,
    input  wire logic        fast_pwm_clock,
    input  wire logic        cell_three_out,
    input  wire logic        cell_four_out,
    input  wire logic        comparator_one_out,
    input  wire logic        comparator_two_out,
    input  wire logic        comparator_three_out,
    input  wire logic        conversion_done,
    input  wire logic        capture_one_sync,
    input  wire logic        capture_two_sync,
    input  wire logic        uart_two_rx,
    input  wire logic        dma_one_irq,
    input  wire logic        compare_one_sync,
    input  wire logic        compare_three_sync,
    input  wire logic        trigger_gen_out_29,
    input  wire logic        pwm_sync_out,
    // Gate outputs toward the logic function core
    output logic      [3:0]  gate_out
);
    import lcis_pkg::*;

    // Registers
    logic [15:0] gate_select_low_q,  gate_select_low_d;
    logic [15:0] gate_select_high_q, gate_select_high_d;
    logic [15:0] source_select_q,    source_select_d;
    logic [3:0]  gate_invert_q,      gate_invert_d;
    logic [31:0] prdata_q,           prdata_d;
    logic        pslverr_q,          pslverr_d;

    // Selector outputs and gate results
    logic [3:0]  src_true;
    logic [3:0]  src_neg;
    logic [3:0]  gate_raw;
    sel_code_t   sel_one, sel_two, sel_three, sel_four;
    logic        addr_hit;
    logic        access;
    logic [7:0]  gate_enables [NUM_GATES];

    // Bus decode
    logic        hit_low;
    logic        hit_high;
    logic        hit_src;
    logic        hit_inv;
    logic        hit_stat;
    logic        wr_access;
    logic [31:0] rd_mux;

    assign access = psel & penable;

    // Selector codes from the source select register
    always_comb begin
        sel_one   = sel_code_t'(source_select_q[0*SEL_FIELD_STRIDE +: SEL_FIELD_WIDTH]);
        sel_two   = sel_code_t'(source_select_q[1*SEL_FIELD_STRIDE +: SEL_FIELD_WIDTH]);
        sel_three = sel_code_t'(source_select_q[2*SEL_FIELD_STRIDE +: SEL_FIELD_WIDTH]);
        sel_four  = sel_code_t'(source_select_q[3*SEL_FIELD_STRIDE +: SEL_FIELD_WIDTH]);
    end

    // Selector one
    always_comb begin
        unique case (sel_one)
            SEL_CODE_0: src_true[0] = ext_input_a;
            SEL_CODE_1: src_true[0] = pwm_gen7_high;
            SEL_CODE_2: src_true[0] = timer1_match;
            SEL_CODE_3: src_true[0] = internal_rc_clock;
            SEL_CODE_4: src_true[0] = reference_clock_out;
            SEL_CODE_5: src_true[0] = fast_pwm_clock;
            SEL_CODE_6: src_true[0] = timer2_match;
            SEL_CODE_7: src_true[0] = pwm_gen1_low;
        endcase
    end

    // Selector two
    always_comb begin
        unique case (sel_two)
            SEL_CODE_0: src_true[1] = ext_input_b;
            SEL_CODE_1: src_true[1] = cell_three_out;
            SEL_CODE_2: src_true[1] = comparator_one_out;
            SEL_CODE_3: src_true[1] = pwm_gen7_low;
            SEL_CODE_4: src_true[1] = conversion_done;
            SEL_CODE_5: src_true[1] = pwm_gen1_high;
            SEL_CODE_6: src_true[1] = capture_one_sync;
            SEL_CODE_7: src_true[1] = capture_two_sync;
        endcase
    end

    // Selector three; own output feeds back, so the core must register it
    always_comb begin
        unique case (sel_three)
            SEL_CODE_0: src_true[2] = ext_input_a;
            SEL_CODE_1: src_true[2] = cell_four_out;
            SEL_CODE_2: src_true[2] = comparator_two_out;
            SEL_CODE_3: src_true[2] = pwm_gen8_high;
            SEL_CODE_4: src_true[2] = uart_two_rx;
            SEL_CODE_5: src_true[2] = dma_one_irq;
            SEL_CODE_6: src_true[2] = compare_one_sync;
            SEL_CODE_7: src_true[2] = pwm_gen2_low;
        endcase
    end

    // Selector four
    always_comb begin
        unique case (sel_four)
            SEL_CODE_0: src_true[3] = ext_input_b;
            SEL_CODE_1: src_true[3] = cell_three_out;
            SEL_CODE_2: src_true[3] = comparator_three_out;
            SEL_CODE_3: src_true[3] = pwm_gen8_low;
            SEL_CODE_4: src_true[3] = trigger_gen_out_29;
            SEL_CODE_5: src_true[3] = pwm_gen2_high;
            SEL_CODE_6: src_true[3] = pwm_sync_out;
            SEL_CODE_7: src_true[3] = compare_three_sync;
        endcase
    end

    // Complement formed once here and shared by all four gates
    assign src_neg = ~src_true;

    // Enable bytes per gate; gates one and two share the low register
    always_comb begin
        gate_enables[0] = gate_select_low_q[0 +: GATE_FIELD_WIDTH];
        gate_enables[1] = gate_select_low_q[GATE_HIGH_LSB +: GATE_FIELD_WIDTH];
        gate_enables[2] = gate_select_high_q[0 +: GATE_FIELD_WIDTH];
        gate_enables[3] = gate_select_high_q[GATE_HIGH_LSB +: GATE_FIELD_WIDTH];
    end

    // Four gates, each fed one enable byte
    input_gate u_gate1 (
        .src_true (src_true),
        .src_neg  (src_neg),
        .enables  (gate_enables[0]),
        .invert   (gate_invert_q[0]),
        .gate_out (gate_raw[0])
    );
    input_gate u_gate2 (
        .src_true (src_true),
        .src_neg  (src_neg),
        .enables  (gate_enables[1]),
        .invert   (gate_invert_q[1]),
        .gate_out (gate_raw[1])
    );
    input_gate u_gate3 (
        .src_true (src_true),
        .src_neg  (src_neg),
        .enables  (gate_enables[2]),
        .invert   (gate_invert_q[2]),
        .gate_out (gate_raw[2])
    );
    input_gate u_gate4 (
        .src_true (src_true),
        .src_neg  (src_neg),
        .enables  (gate_enables[3]),
        .invert   (gate_invert_q[3]),
        .gate_out (gate_raw[3])
    );

    // Combinational path keeps gate latency at zero for the core
    assign gate_out = gate_raw;

    // Address decode shared by the read and write paths
    // Full compare, so no register appears again at an alias offset
    always_comb begin
        hit_low  = (paddr == GATE_SELECT_LOW_ADDR);
        hit_high = (paddr == GATE_SELECT_HIGH_ADDR);
        hit_src  = (paddr == SOURCE_SELECT_ADDR);
        hit_inv  = (paddr == GATE_INVERT_ADDR);
        hit_stat = (paddr == STATUS_ADDR);
        addr_hit = hit_low | hit_high | hit_src | hit_inv | hit_stat;
    end

    // Writes land only at the access edge, where the master sees ready
    assign wr_access = access & pwrite & addr_hit;

    // Read mux; unmapped offsets and unimplemented bits read as zero
    always_comb begin
        rd_mux = 32'h00000000;
        if (hit_low) begin
            rd_mux = {16'h0000, gate_select_low_q};
        end
        if (hit_high) begin
            rd_mux = {16'h0000, gate_select_high_q};
        end
        if (hit_src) begin
            rd_mux = {16'h0000, source_select_q};
        end
        if (hit_inv) begin
            rd_mux = {28'h0000000, gate_invert_q};
        end
        if (hit_stat) begin
            // Live view of the selected sources and gate results
            rd_mux = {20'h00000, src_true, 4'h0, gate_raw};
        end
    end

    // Configuration registers next state
    always_comb begin
        gate_select_low_d  = gate_select_low_q;
        gate_select_high_d = gate_select_high_q;
        source_select_d    = source_select_q;
        gate_invert_d      = gate_invert_q;
        if (wr_access && hit_low) begin
            gate_select_low_d = pwdata[15:0];
        end
        if (wr_access && hit_high) begin
            gate_select_high_d = pwdata[15:0];
        end
        if (wr_access && hit_src) begin
            // Only the selector fields are kept; the gaps between them stay zero
            for (int k = 0; k < NUM_SOURCES; k++) begin
                source_select_d[k*SEL_FIELD_STRIDE +: SEL_FIELD_WIDTH] =
                    pwdata[k*SEL_FIELD_STRIDE +: SEL_FIELD_WIDTH];
            end
        end
        if (wr_access && hit_inv) begin
            // Only the low bits of the invert word are implemented
            gate_invert_d = pwdata[3:0];
        end
    end

    // Sync reset brings every gate to its empty, non-inverted state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gate_select_low_q  <= GATE_SELECT_LOW_RST;
            gate_select_high_q <= GATE_SELECT_HIGH_RST;
            source_select_q    <= SOURCE_SELECT_RST;
            gate_invert_q      <= GATE_INVERT_RST;
        end else begin
            gate_select_low_q  <= gate_select_low_d;
            gate_select_high_q <= gate_select_high_d;
            source_select_q    <= source_select_d;
            gate_invert_q      <= gate_invert_d;
        end
    end

    // Bus response next state; read data is fixed in the setup cycle so it
    // stands unchanged through the access edge
    always_comb begin
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (psel && !penable) begin
            prdata_d  = rd_mux;
            pslverr_d = ~addr_hit;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Decode in setup, answer in the first access cycle
    assign pready  = access;
    assign prdata  = prdata_q;
    assign pslverr = access & pslverr_q;

endmodule : logic_cell_input_select

// >>> test/src_model.sv
// Model of the on-chip signals and pins feeding the selectors
`timescale 1ns/1ps
module src_model (
    // Clock
    input  wire logic        sys_clk,
    // Source levels, index order as the bench lists them
    output logic      [28:0] src
);
    // New levels every cycle, so every selector path is exercised
    initial begin
        src = '0;
        forever @(posedge sys_clk) src <= 29'($urandom);
    end
endmodule : src_model

// >>> test/lcis_chk.sv
// Checker for the input select stage, bound to its ports
`timescale 1ns/1ps
module lcis_chk (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    // Sources and gates
    input wire logic        ext_input_a,
    input wire logic        cell_three_out,
    input wire logic [3:0]  gate_out
);
    import lcis_pkg::*;
    logic [15:0] gl_q, gl_d, gh_q, gh_d, ss_q, ss_d;
    logic [3:0]  inv_q, inv_d;
    logic        wr;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Shadow copies; writes land at the access edge
    always_comb begin
        wr = psel && penable && pwrite;
        gl_d = (wr && paddr == GATE_SELECT_LOW_ADDR) ? pwdata[15:0] : gl_q;
        gh_d = (wr && paddr == GATE_SELECT_HIGH_ADDR) ? pwdata[15:0] : gh_q;
        ss_d = (wr && paddr == SOURCE_SELECT_ADDR) ? pwdata[15:0] : ss_q;
        inv_d = (wr && paddr == GATE_INVERT_ADDR) ? pwdata[3:0] : inv_q;
    end
    always_ff @(posedge sys_clk) begin
        {gl_q, gh_q, ss_q, inv_q} <= rst ? '0 : {gl_d, gh_d, ss_d, inv_d};
    end
    a_empty_gate_one: assert property (gl_q[7:0] == 8'h00 && !inv_q[0] |-> !gate_out[0])
        else $error("gate one not low with no enables");
    a_empty_gate_two: assert property (gl_q[15:8] == 8'h00 && !inv_q[1] |-> !gate_out[1])
        else $error("gate two not low with no enables");
    a_empty_gate_three: assert property (gh_q[7:0] == 8'h00 && !inv_q[2] |-> !gate_out[2])
        else $error("gate three not low with no enables");
    a_empty_gate_four: assert property (gh_q[15:8] == 8'h00 && !inv_q[3] |-> !gate_out[3])
        else $error("gate four not low with no enables");
    a_both_copies: assert property (gl_q[1:0] == 2'b11 && !inv_q[0] |-> gate_out[0])
        else $error("true or negated copy missing in gate one");
    a_gate_invert: assert property (gl_q[7:0] == 8'h00 && inv_q[0] |-> gate_out[0])
        else $error("gate one inversion not applied");
    a_route_sel_one: assert property (
        ss_q[2:0] == 3'h0 && gl_q[7:0] == 8'h02 && !inv_q[0] |-> gate_out[0] == ext_input_a)
        else $error("selector one code 0 misrouted");
    a_route_sel_two: assert property (
        ss_q[6:4] == 3'h1 && gl_q[15:8] == 8'h08 && !inv_q[1] |-> gate_out[1] == cell_three_out)
        else $error("selector two code 1 misrouted");
    a_ready_access: assert property ($rose(penable) && psel |-> pready ##1 !pready)
        else $error("ready not a one cycle answer");
    c_write: cover property (wr);
    c_all_enabled: cover property (gl_q == 16'hffff && gh_q == 16'hffff);
    c_all_inverted: cover property (inv_q == 4'hf);
    c_status_read: cover property (psel && penable && !pwrite && paddr == STATUS_ADDR);
endmodule : lcis_chk
bind logic_cell_input_select lcis_chk u_chk (
    .sys_clk        (sys_clk),
    .rst            (rst),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .pready         (pready),
    .ext_input_a    (ext_input_a),
    .cell_three_out (cell_three_out),
    .gate_out       (gate_out)
);

// >>> test/tb.sv
// Self-checking bench for the input select stage
`timescale 1ns/1ps
module tb;
    import lcis_pkg::*;
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [28:0] src;
    logic [15:0] gl, gh, ss;
    logic [3:0] gate_out, inv, es, eg;
    logic [28:0] snap;
    logic [7:0] cfg_addr [4] = '{GATE_SELECT_LOW_ADDR, GATE_SELECT_HIGH_ADDR,
                                 SOURCE_SELECT_ADDR, GATE_INVERT_ADDR};
    int n_fail, n_checks;
    // Source index per code, one row per selector
    int mux [4][8] = '{'{0, 2, 10, 12, 13, 14, 11, 7},
                       '{1, 15, 17, 3, 20, 6, 21, 22},
                       '{0, 16, 18, 4, 23, 24, 25, 9},
                       '{1, 15, 19, 5, 27, 8, 28, 26}};
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    src_model u_src (.sys_clk(sys_clk), .src(src));
    logic_cell_input_select u_dut (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_input_a(src[0]), .ext_input_b(src[1]), .pwm_gen7_high(src[2]),
        .pwm_gen7_low(src[3]), .pwm_gen8_high(src[4]), .pwm_gen8_low(src[5]),
        .pwm_gen1_high(src[6]), .pwm_gen1_low(src[7]), .pwm_gen2_high(src[8]),
        .pwm_gen2_low(src[9]), .timer1_match(src[10]), .timer2_match(src[11]),
        .internal_rc_clock(src[12]), .reference_clock_out(src[13]), .fast_pwm_clock(src[14]),
        .cell_three_out(src[15]), .cell_four_out(src[16]), .comparator_one_out(src[17]),
        .comparator_two_out(src[18]), .comparator_three_out(src[19]),
        .conversion_done(src[20]), .capture_one_sync(src[21]), .capture_two_sync(src[22]),
        .uart_two_rx(src[23]), .dma_one_irq(src[24]), .compare_one_sync(src[25]),
        .compare_three_sync(src[26]), .trigger_gen_out_29(src[27]), .pwm_sync_out(src[28]),
        .gate_out(gate_out));
    function automatic logic [3:0] expect_srcs(logic [28:0] s, logic [15:0] sel);
        logic [3:0] d;
        for (int k = 0; k < 4; k++) d[k] = s[mux[k][sel[4*k +: 3]]];
        return d;
    endfunction : expect_srcs
    function automatic logic [3:0] expect_gates(logic [28:0] s, logic [15:0] sel,
            logic [31:0] en, logic [3:0] iv);
        logic [3:0] d, g;
        logic [7:0] p;
        d = expect_srcs(s, sel);
        p = {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]};
        for (int j = 0; j < 4; j++) g[j] = (|(en[8*j +: 8] & p)) ^ iv[j];
        return g;
    endfunction : expect_gates
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Holds the request until ready is seen at a rising edge
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge sys_clk);
        // Sources as the design sees them in the setup cycle
        snap = src;
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #100000;
        n_fail++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h5fb51233));
        {psel, penable, pwrite, paddr, pwdata} = '0;
        rst = 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, GATE_SELECT_LOW_ADDR, 32'h0);
        check("gate_select_low reset", 32'h0, rd);
        apb(1'b0, GATE_SELECT_HIGH_ADDR, 32'h0);
        check("gate_select_high reset", 32'h0, rd);
        check("gate_out reset", 32'h0, {28'h0, gate_out});
        apb(1'b1, 8'h40, 32'hffff);
        check("unmapped error", 32'h1, {31'h0, er});
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped read data", 32'h0, rd);
        check("unmapped read error", 32'h1, {31'h0, er});
        apb(1'b0, GATE_SELECT_LOW_ADDR, 32'h0);
        check("gate_select_low after unmapped write", 32'h0, rd);
        apb(1'b1, STATUS_ADDR, 32'hffffffff);
        check("status write error", 32'h0, {31'h0, er});
        // Every code on every selector first, then corner and random settings
        for (int i = 0; i < 40; i++) begin
            ss = (i < 8) ? {4{1'b0, i[2:0]}} : 16'($urandom);
            gl = (i < 8) ? 16'h0802 : 16'($urandom);
            gh = 16'($urandom);
            inv = (i < 8) ? 4'h0 : 4'($urandom);
            if (i == 8) {gl, gh, inv} = '0;
            if (i == 9) {gl, gh, inv} = {32'hffffffff, 4'h0};
            if (i == 10) {gl, gh, inv} = {32'h0, 4'hf};
            apb(1'b1, SOURCE_SELECT_ADDR, {16'h0, ss});
            apb(1'b1, GATE_SELECT_LOW_ADDR, {16'h0, gl});
            apb(1'b1, GATE_SELECT_HIGH_ADDR, {16'h0, gh});
            apb(1'b1, GATE_INVERT_ADDR, {28'h0, inv});
            apb(1'b0, GATE_SELECT_LOW_ADDR, 32'h0);
            check("gate_select_low", {16'h0, gl}, rd);
            apb(1'b0, GATE_SELECT_HIGH_ADDR, 32'h0);
            check("gate_select_high", {16'h0, gh}, rd);
            apb(1'b0, SOURCE_SELECT_ADDR, 32'h0);
            check("source_select", {16'h0, ss & 16'h7777}, rd);
            apb(1'b0, GATE_INVERT_ADDR, 32'h0);
            check("gate_invert", {28'h0, inv}, rd);
            apb(1'b0, STATUS_ADDR, 32'h0);
            es = expect_srcs(snap, ss);
            eg = expect_gates(snap, ss, {gh, gl}, inv);
            check("status", {20'h0, es, 4'h0, eg}, rd);
            repeat (6) begin
                @(negedge sys_clk);
                check("gate_out", {28'h0, expect_gates(src, ss, {gh, gl}, inv)}, {28'h0, gate_out});
            end
        end
        // Reset in mid-run must clear every register again
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (cfg_addr[a]) begin
            apb(1'b0, cfg_addr[a], 32'h0);
            check("register after reset", 32'h0, rd);
        end
        check("gate_out after reset", 32'h0, {28'h0, gate_out});
        give_verdict();
    end
endmodule : tb
